// >>> shared/aod_pkg.sv
package aod_pkg;

   // ---------------------------------------------------------------------
   // register pages and offsets
   // ---------------------------------------------------------------------
   localparam logic       PAGE_ZERO          = 1'b0;
   localparam logic       PAGE_ONE           = 1'b1;
   localparam logic [6:0] OFS_OVERTEMP       = 7'h03;  // page 0
   localparam logic [6:0] OFS_STEP_TIME      = 7'h3f;  // page 0
   localparam logic [6:0] OFS_HP_CTRL        = 7'h1f;  // page 1
   localparam logic [6:0] OFS_SPK_CTRL       = 7'h20;  // page 1
   localparam logic [6:0] OFS_DAC_ROUTE      = 7'h23;  // page 1
   localparam logic [6:0] OFS_SPK_VOL        = 7'h26;  // page 1
   localparam logic [6:0] OFS_HPL_GAIN       = 7'h28;  // page 1
   localparam logic [6:0] OFS_HPR_GAIN       = 7'h29;  // page 1
   localparam logic [6:0] OFS_SPK_GAIN       = 7'h2a;  // page 1
   localparam logic [6:0] OFS_HP_CFG         = 7'h2c;  // page 1

   // ---------------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------------
   localparam int BIT_OT_FLAG      = 1;  // overtemperature status
   localparam int BIT_HPL_PWR      = 7;  // headphone control
   localparam int BIT_HPR_PWR      = 6;
   localparam int BIT_CM_HI        = 4;
   localparam int BIT_CM_LO        = 3;
   localparam int BIT_SC_MODE      = 1;
   localparam int BIT_HP_SC_FLAG   = 0;
   localparam int BIT_SPK_PWR      = 7;  // speaker control
   localparam int BIT_SPK_SC_FLAG  = 0;
   localparam int BIT_DACL_ROUTE   = 6;  // dac routing
   localparam int BIT_VOL_ROUTE    = 7;  // speaker volume
   localparam int BIT_VOL_HI       = 6;
   localparam int BIT_HPG_HI       = 6;  // headphone gain
   localparam int BIT_HPG_LO       = 3;
   localparam int BIT_MUTE_N       = 2;  // shared by all gain registers
   localparam int BIT_SPKG_HI      = 4;  // speaker gain
   localparam int BIT_SPKG_LO      = 3;
   localparam int BIT_LINEOUT_HI   = 2;  // drive config
   localparam int BIT_LINEOUT_LO   = 1;
   localparam int BIT_STEP_HI      = 1;  // soft-step time
   localparam logic [1:0] LINEOUT_CODE  = 2'h3;
   localparam logic [6:0] VOL_MUTE_CODE = 7'h7f;
   localparam logic [1:0] STEP_OFF_CODE = 2'h3;

   // ---------------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------------
   localparam logic [7:0] RST_REG  = 8'h00;
   localparam logic [6:0] RST_VOL  = 7'h00;

   // ---------------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------------
   localparam int CLK_MHZ      = 200;
   localparam int STEP0_US     = 61;
   localparam int STEP1_US     = 122;
   localparam int STEP2_US     = 244;
   localparam int SOFTSTART_US = 100;
   localparam int STEP0_CYC    = STEP0_US * CLK_MHZ;
   localparam int STEP1_CYC    = STEP1_US * CLK_MHZ;
   localparam int STEP2_CYC    = STEP2_US * CLK_MHZ;
   localparam int SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;

   // ---------------------------------------------------------------------
   // speaker mix selection
   // ---------------------------------------------------------------------
   typedef enum logic [1:0] {
      AOD_MIX_LEFT  = 2'b00,
      AOD_MIX_RIGHT = 2'b01,
      AOD_MIX_BOTH  = 2'b10,
      AOD_MIX_NONE  = 2'b11
   } aod_mix_e;

endpackage : aod_pkg

// >>> rtl/aod_output_ctrl.sv
`timescale 1ns/10ps
// Function
// - speaker volume spans 0 to -78 dB plus mute, moving by soft steps
// - route bit six connects left DAC to left analog volume
// - seven-bit field sets mono speaker analog volume
// - bit seven routes mono volume output into speaker amplifier
// - two-bit field selects soft-step time per volume step
// - code 11 puts headphone drivers in lineout drive configuration
// - two-bit field picks headphone common-mode level; software keeps it low
// - bits seven and six power left and right headphone drivers
// - each headphone has four-bit gain and a mute bit
// - bit one picks current limit (zero) or shutdown on headphone short
// - headphone short limits or disables output and sets read-only status bit
// - shutdown mode clears the affected headphone power bit at once
// - master reset or rewriting power bit re-enables headphone; fault repeats shutdown
// - speaker power bit, two-bit gain and mute bit
// - speaker overcurrent always shuts stage down and sets read-only flag
// - speaker resumes after master reset or power bit rewrite
// - overtemperature pauses speaker switching, resumes when cool, read-only flag
// - each stage soft-starts when powered; all may start together
// - speaker mix takes left, right or both playback channels
// - volume route zero with all-ones volume mutes the output
module aod_output_ctrl #(
   parameter int STEP0_CYCLES     = aod_pkg::STEP0_CYC,      // soft-step code 0
   parameter int STEP1_CYCLES     = aod_pkg::STEP1_CYC,      // soft-step code 1
   parameter int STEP2_CYCLES     = aod_pkg::STEP2_CYC,      // soft-step code 2
   parameter int SOFTSTART_CYCLES = aod_pkg::SOFTSTART_CYC,  // stage ramp time
   parameter int SAMPLE_W         = 16                       // playback sample width
) (
   input  wire logic                  core_clk,       // 200 MHz clock
   input  wire logic                  rst_n,          // async reset, active low
   input  wire logic                  swReset,        // software master reset pulse
   input  wire logic                  regWrite,       // register write strobe
   input  wire logic                  regRead,        // register read strobe
   input  wire logic                  regPage,        // page select
   input  wire logic [6:0]            regAddr,        // register offset
   input  wire logic [7:0]            regWdata,       // write data
   output logic      [7:0]            regRdata,       // read data
   output logic                       regRvalid,      // read data valid pulse
   input  wire logic                  hplShortPin,    // left headphone short detect
   input  wire logic                  hprShortPin,    // right headphone short detect
   input  wire logic                  spkOverPin,     // speaker overcurrent detect
   input  wire logic                  overTempPin,    // die overtemperature detect
   input  wire logic [1:0]            spkMixSel,      // speaker mix selection
   input  wire logic [SAMPLE_W-1:0]   leftSample,     // left playback sample
   input  wire logic [SAMPLE_W-1:0]   rightSample,    // right playback sample
   output logic      [SAMPLE_W-1:0]   spkSample,      // mixed speaker sample
   output logic                       dacLeftRoute,   // left dac to analog volume
   output logic                       spkVolRoute,    // volume into speaker amp
   output logic                       spkVolMute,     // analog volume muted
   output logic      [6:0]            spkVolNow,      // soft-stepped volume code
   output logic      [1:0]            hpCmLevel,      // common-mode level code
   output logic                       hpLineout,      // lineout drive mode
   output logic      [3:0]            hplGain,        // left headphone gain
   output logic      [3:0]            hprGain,        // right headphone gain
   output logic                       hplMute,        // left headphone mute
   output logic                       hprMute,        // right headphone mute
   output logic      [1:0]            spkGain,        // speaker gain
   output logic                       spkMute,        // speaker mute
   output logic                       hplOn,          // left headphone stage up
   output logic                       hprOn,          // right headphone stage up
   output logic                       spkOn,          // speaker stage up
   output logic                       hplLimit,       // left current limiting
   output logic                       hprLimit,       // right current limiting
   output logic                       spkSwitchEn     // class-d switching enable
);
   import aod_pkg::*;

   // ---------------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------------
   localparam int SC_W = $clog2(STEP2_CYCLES + 1);
   localparam int RC_W = $clog2(SOFTSTART_CYCLES + 1);

   if (STEP0_CYCLES < 1 || STEP1_CYCLES < STEP0_CYCLES || STEP2_CYCLES < STEP1_CYCLES)
      $error("soft-step counts must be positive and ascending");
   if (SOFTSTART_CYCLES < 1)
      $error("soft-start count must be at least one");
   if (SAMPLE_W < 2)
      $error("sample width too small");

   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]            stepReg;
      logic [7:0]            hpCtl;
      logic [7:0]            spkCtl;
      logic [7:0]            routeReg;
      logic [7:0]            volReg;
      logic [7:0]            hplReg;
      logic [7:0]            hprReg;
      logic [7:0]            spkGReg;
      logic [7:0]            cfgReg;
      logic [1:0]            syncHpl;
      logic [1:0]            syncHpr;
      logic [1:0]            syncSpk;
      logic [1:0]            syncOt;
      logic [6:0]            volNow;
      logic [SC_W-1:0]       stepCnt;
      logic [2:0][RC_W-1:0]  rampCnt;
      logic [2:0]            stageOn;
      logic [7:0]            rdData;
      logic                  rdValid;
      logic                  volMute;
      logic [1:0]            limitOut;
      logic                  switchEn;
      logic [SAMPLE_W-1:0]   mixOut;
   } aod_state_s;

   aod_state_s cur;
   aod_state_s next_cur;
   logic [1:0] rstSync;

   // reset release through two flops; asserts at once, releases on the clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end

   // ---------------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------------
   logic                  wrP0;
   logic                  wrP1;
   logic                  hplShort;
   logic                  hprShort;
   logic                  spkOver;
   logic                  overTemp;
   logic                  scShutdown;
   logic [SC_W-1:0]       stepLimit;
   logic                  stepDue;
   logic [2:0]            pwrBit;
   logic [SAMPLE_W:0]     mixSum;

   always_comb begin
      next_cur   = cur;
      wrP0       = regWrite && (regPage == PAGE_ZERO);
      wrP1       = regWrite && (regPage == PAGE_ONE);
      // only the second synchroniser stage is looked at
      hplShort   = cur.syncHpl[1];
      hprShort   = cur.syncHpr[1];
      spkOver    = cur.syncSpk[1];
      overTemp   = cur.syncOt[1];
      scShutdown = cur.hpCtl[BIT_SC_MODE];
      stepLimit  = '0;
      stepDue    = 1'b0;
      pwrBit     = 3'b000;
      mixSum     = '0;

      next_cur.syncHpl = {cur.syncHpl[0], hplShortPin};
      next_cur.syncHpr = {cur.syncHpr[0], hprShortPin};
      next_cur.syncSpk = {cur.syncSpk[0], spkOverPin};
      next_cur.syncOt  = {cur.syncOt[0], overTempPin};

      // register writes; status bit 0 of each control register is read-only
      if (wrP0 && regAddr == OFS_STEP_TIME) next_cur.stepReg = regWdata;
      if (wrP1) begin
         case (regAddr)
            OFS_HP_CTRL: begin
               next_cur.hpCtl[7:1] = regWdata[7:1];
            end
            OFS_SPK_CTRL: begin
               next_cur.spkCtl[7:1] = regWdata[7:1];
            end
            OFS_DAC_ROUTE: next_cur.routeReg = regWdata;
            OFS_SPK_VOL:   next_cur.volReg   = regWdata;
            OFS_HPL_GAIN:  next_cur.hplReg   = regWdata;
            OFS_HPR_GAIN:  next_cur.hprReg   = regWdata;
            OFS_SPK_GAIN:  next_cur.spkGReg  = regWdata;
            OFS_HP_CFG:    next_cur.cfgReg   = regWdata;
            default: begin
            end
         endcase
      end

      // a power-stage reset (writing the power bit as one) clears the flag
      if (wrP1 && regAddr == OFS_HP_CTRL
          && (regWdata[BIT_HPL_PWR] || regWdata[BIT_HPR_PWR])) begin
         next_cur.hpCtl[BIT_HP_SC_FLAG] = 1'b0;
      end
      if (wrP1 && regAddr == OFS_SPK_CTRL && regWdata[BIT_SPK_PWR]) begin
         next_cur.spkCtl[BIT_SPK_SC_FLAG] = 1'b0;
      end

      // short detection comes after the writes so a new fault wins
      if ((hplShort && cur.stageOn[0]) || (hprShort && cur.stageOn[1])) begin
         next_cur.hpCtl[BIT_HP_SC_FLAG] = 1'b1;
      end
      if (scShutdown && hplShort && cur.hpCtl[BIT_HPL_PWR]) begin
         next_cur.hpCtl[BIT_HPL_PWR] = 1'b0;
      end
      if (scShutdown && hprShort && cur.hpCtl[BIT_HPR_PWR]) begin
         next_cur.hpCtl[BIT_HPR_PWR] = 1'b0;
      end
      // speaker has no limiting choice: any overcurrent drops the power bit
      if (spkOver && cur.spkCtl[BIT_SPK_PWR]) begin
         next_cur.spkCtl[BIT_SPK_PWR]     = 1'b0;
         next_cur.spkCtl[BIT_SPK_SC_FLAG] = 1'b1;
      end

      // limiting only while the stage is up and limit mode is chosen
      next_cur.limitOut[0] = !scShutdown && hplShort && cur.stageOn[0];
      next_cur.limitOut[1] = !scShutdown && hprShort && cur.stageOn[1];

      // soft-start ramps; each stage has its own counter so all may start at once
      pwrBit = {next_cur.spkCtl[BIT_SPK_PWR], next_cur.hpCtl[BIT_HPR_PWR],
                next_cur.hpCtl[BIT_HPL_PWR]};
      for (int i = 0; i < 3; i++) begin
         if (!pwrBit[i]) begin
            next_cur.rampCnt[i] = '0;
            next_cur.stageOn[i] = 1'b0;
         end else if (!cur.stageOn[i]) begin
            if (cur.rampCnt[i] == RC_W'(SOFTSTART_CYCLES - 1)) begin
               next_cur.stageOn[i] = 1'b1;
            end else begin
               next_cur.rampCnt[i] = cur.rampCnt[i] + 1'b1;
            end
         end
      end

      // switching pauses while hot and comes back by itself on cooling
      next_cur.switchEn = next_cur.stageOn[2] && !overTemp;

      // volume soft-stepping toward the written code, one code per step time
      case (cur.stepReg[BIT_STEP_HI:0])
         2'b00:   stepLimit = SC_W'(STEP0_CYCLES - 1);
         2'b01:   stepLimit = SC_W'(STEP1_CYCLES - 1);
         2'b10:   stepLimit = SC_W'(STEP2_CYCLES - 1);
         default: stepLimit = '0;
      endcase
      if (cur.stepReg[BIT_STEP_HI:0] == STEP_OFF_CODE) begin
         next_cur.volNow  = cur.volReg[BIT_VOL_HI:0];
         next_cur.stepCnt = '0;
      end else if (cur.volNow == cur.volReg[BIT_VOL_HI:0]) begin
         next_cur.stepCnt = '0;
      end else begin
         stepDue = (cur.stepCnt >= stepLimit);
         next_cur.stepCnt = stepDue ? '0 : cur.stepCnt + 1'b1;
         if (stepDue && cur.volNow < cur.volReg[BIT_VOL_HI:0]) begin
            next_cur.volNow = cur.volNow + 1'b1;
         end else if (stepDue) begin
            next_cur.volNow = cur.volNow - 1'b1;
         end
      end
      next_cur.volMute = !cur.volReg[BIT_VOL_ROUTE]
                         && cur.volReg[BIT_VOL_HI:0] == VOL_MUTE_CODE;

      // digital mix for the mono speaker; averaging avoids overflow on both
      mixSum = {leftSample[SAMPLE_W-1], leftSample}
             + {rightSample[SAMPLE_W-1], rightSample};
      case (aod_mix_e'(spkMixSel))
         AOD_MIX_LEFT:  next_cur.mixOut = leftSample;
         AOD_MIX_RIGHT: next_cur.mixOut = rightSample;
         AOD_MIX_BOTH:  next_cur.mixOut = mixSum[SAMPLE_W:1];
         default:       next_cur.mixOut = '0;
      endcase

      // reads return register state and have no side effect
      next_cur.rdValid = regRead;
      next_cur.rdData  = RST_REG;
      if (regRead && regPage == PAGE_ZERO) begin
         case (regAddr)
            OFS_OVERTEMP:  next_cur.rdData = 8'(overTemp) << BIT_OT_FLAG;
            OFS_STEP_TIME: next_cur.rdData = cur.stepReg;
            default:       next_cur.rdData = RST_REG;
         endcase
      end else if (regRead) begin
         case (regAddr)
            OFS_HP_CTRL:   next_cur.rdData = cur.hpCtl;
            OFS_SPK_CTRL:  next_cur.rdData = cur.spkCtl;
            OFS_DAC_ROUTE: next_cur.rdData = cur.routeReg;
            OFS_SPK_VOL:   next_cur.rdData = cur.volReg;
            OFS_HPL_GAIN:  next_cur.rdData = cur.hplReg;
            OFS_HPR_GAIN:  next_cur.rdData = cur.hprReg;
            OFS_SPK_GAIN:  next_cur.rdData = cur.spkGReg;
            OFS_HP_CFG:    next_cur.rdData = cur.cfgReg;
            default:       next_cur.rdData = RST_REG;
         endcase
      end

      // master reset clears every register but keeps the pin synchronisers
      if (swReset) begin
         next_cur          = '0;
         next_cur.volNow   = RST_VOL;
         next_cur.syncHpl  = {cur.syncHpl[0], hplShortPin};
         next_cur.syncHpr  = {cur.syncHpr[0], hprShortPin};
         next_cur.syncSpk  = {cur.syncSpk[0], spkOverPin};
         next_cur.syncOt   = {cur.syncOt[0], overTempPin};
      end
   end

   // ---------------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstSync[1]) begin
      if (!rstSync[1]) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // ---------------------------------------------------------------------
   // outputs, all taken from state flops
   // ---------------------------------------------------------------------
   assign regRdata     = cur.rdData;
   assign regRvalid    = cur.rdValid;
   assign spkSample    = cur.mixOut;
   assign dacLeftRoute = cur.routeReg[BIT_DACL_ROUTE];
   assign spkVolRoute  = cur.volReg[BIT_VOL_ROUTE];
   assign spkVolMute   = cur.volMute;
   assign spkVolNow    = cur.volNow;
   assign hpCmLevel    = cur.hpCtl[BIT_CM_HI:BIT_CM_LO];
   assign hpLineout    = cur.cfgReg[BIT_LINEOUT_HI:BIT_LINEOUT_LO] == LINEOUT_CODE;
   assign hplGain      = cur.hplReg[BIT_HPG_HI:BIT_HPG_LO];
   assign hprGain      = cur.hprReg[BIT_HPG_HI:BIT_HPG_LO];
   assign hplMute      = cur.hplReg[BIT_MUTE_N];
   assign hprMute      = cur.hprReg[BIT_MUTE_N];
   assign spkGain      = cur.spkGReg[BIT_SPKG_HI:BIT_SPKG_LO];
   assign spkMute      = cur.spkGReg[BIT_MUTE_N];
   assign hplOn        = cur.stageOn[0];
   assign hprOn        = cur.stageOn[1];
   assign spkOn        = cur.stageOn[2];
   assign hplLimit     = cur.limitOut[0];
   assign hprLimit     = cur.limitOut[1];
   assign spkSwitchEn  = cur.switchEn;

endmodule : aod_output_ctrl

// >>> dv/aod_output_ctrl_properties.sv
`timescale 1ns/10ps
module aod_output_ctrl_chk import aod_pkg::*; (
   input wire logic       core_clk, rst_n, swReset, regWrite, regPage,   // clock, reset, bus
   input wire logic [6:0] regAddr,                                        // offset
   input wire logic [7:0] regWdata,                                       // write data
   input wire logic       overTempPin, spkOverPin, dacLeftRoute, spkVolRoute, spkVolMute,
   input wire logic       hpLineout, hplMute, spkMute, spkSwitchEn, spkOn, hplOn,
   input wire logic [3:0] hplGain,                                        // left gain
   input wire logic [1:0] spkGain                                         // speaker gain
);
   // ---------------------------------------------------------------
   // page one write relations, fault and thermal responses
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic w1;
   // a master reset pulse on the same edge would zero the register instead
   assign w1 = regWrite && regPage && !swReset;
   property p_route;
      w1 && regAddr == OFS_DAC_ROUTE |-> ##2 dacLeftRoute == $past(regWdata[6], 2); endproperty
   a_route: assert property (p_route) else $error("dac route bit lost");
   property p_vroute;
      w1 && regAddr == OFS_SPK_VOL |-> ##2 spkVolRoute == $past(regWdata[7], 2); endproperty
   a_vroute: assert property (p_vroute) else $error("volume route bit lost");
   property p_volmute;
      w1 && regAddr == OFS_SPK_VOL && regWdata == 8'h7f |-> ##[2:3] spkVolMute; endproperty
   a_volmute: assert property (p_volmute) else $error("volume mute missing");
   property p_lineout;
      w1 && regAddr == OFS_HP_CFG |-> ##2 hpLineout == ($past(regWdata[2:1], 2) == 2'h3);
   endproperty
   a_lineout: assert property (p_lineout) else $error("lineout decode wrong");
   property p_hpg;
      w1 && regAddr == OFS_HPL_GAIN |-> ##2 hplGain == $past(regWdata[6:3], 2)
         && hplMute == $past(regWdata[2], 2); endproperty
   a_hpg: assert property (p_hpg) else $error("left gain field wrong");
   property p_spkg;
      w1 && regAddr == OFS_SPK_GAIN |-> ##2 spkGain == $past(regWdata[4:3], 2)
         && spkMute == $past(regWdata[2], 2); endproperty
   a_spkg: assert property (p_spkg) else $error("speaker gain field wrong");
   property p_otp; overTempPin [*4] |-> !spkSwitchEn; endproperty
   a_otp: assert property (p_otp) else $error("switching while hot");
   property p_spksc; spkOverPin [*6] |-> !spkOn; endproperty
   a_spksc: assert property (p_spksc) else $error("speaker up during overcurrent");
   c_allon: cover property (hplOn && spkOn);
   c_hot: cover property (spkOn && !spkSwitchEn);
   c_line: cover property (hpLineout);
endmodule : aod_output_ctrl_chk

bind aod_output_ctrl aod_output_ctrl_chk u_chk (.core_clk, .rst_n, .swReset, .regWrite,
   .regPage, .regAddr, .regWdata, .overTempPin, .spkOverPin, .dacLeftRoute, .spkVolRoute,
   .spkVolMute, .hpLineout, .hplMute, .spkMute, .spkSwitchEn, .spkOn, .hplOn, .hplGain,
   .spkGain);

// >>> dv/aod_output_ctrl_test.sv
`timescale 1ns/10ps
module aod_output_ctrl_test;
   import aod_pkg::*;
   // ---------------------------------------------------------------
   // stimulus, dut and scenarios
   // ---------------------------------------------------------------
   logic core_clk, rst_n, swReset, regWrite, regRead, regPage, hplShortPin, hprShortPin;
   logic spkOverPin, overTempPin, regRvalid, dacLeftRoute, spkVolRoute, spkVolMute, hpLineout;
   logic hplMute, hprMute, spkMute, hplOn, hprOn, spkOn, hplLimit, hprLimit, spkSwitchEn;
   logic [1:0] spkMixSel, hpCmLevel, spkGain;
   logic [3:0] hplGain, hprGain;
   logic [6:0] regAddr, spkVolNow;
   logic [7:0] regWdata, regRdata;
   logic [15:0] leftSample, rightSample, spkSample;
   int failures, samples_checked;
   // short counts keep soft-start and soft-step runs brief
   aod_output_ctrl #(.STEP0_CYCLES(4), .STEP1_CYCLES(8), .STEP2_CYCLES(12),
      .SOFTSTART_CYCLES(10)) u_dut (.core_clk, .rst_n, .swReset, .regWrite, .regRead,
      .regPage, .regAddr, .regWdata, .regRdata, .regRvalid, .hplShortPin, .hprShortPin,
      .spkOverPin, .overTempPin, .spkMixSel, .leftSample, .rightSample, .spkSample,
      .dacLeftRoute, .spkVolRoute, .spkVolMute, .spkVolNow, .hpCmLevel, .hpLineout,
      .hplGain, .hprGain, .hplMute, .hprMute, .spkGain, .spkMute, .hplOn, .hprOn, .spkOn,
      .hplLimit, .hprLimit, .spkSwitchEn);
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         failures++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic p, input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {regWrite, regPage, regAddr, regWdata} <= {1'b1, p, a, d};
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   // read data stands one cycle only, so it is sampled just after that edge
   task automatic rd(input logic p, input logic [6:0] a, input logic [7:0] e);
      @(posedge core_clk);
      {regRead, regPage, regAddr} <= {1'b1, p, a};
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 chk(regRvalid === 1'b1 && regRdata === e, "read data");
   endtask : rd
   task automatic t_regs();
      logic [6:0] ofs [10] = '{7'h03, 7'h3f, 7'h1f, 7'h20, 7'h23,
                               7'h26, 7'h28, 7'h29, 7'h2a, 7'h2c};
      for (int i = 0; i < 10; i++) rd(i > 1, ofs[i], 8'h00);
      wr(0, 7'h03, 8'hff);
      rd(0, 7'h03, 8'h00);
      wr(1, 7'h1f, 8'h01);
      rd(1, 7'h1f, 8'h00);
      rd(1, 7'h10, 8'h00);
      $display("test regs done");
   endtask : t_regs
   task automatic t_fields();
      wr(0, 7'h3f, 8'h03);
      wr(1, 7'h23, 8'h40);
      wr(1, 7'h28, 8'h7c);
      wr(1, 7'h29, 8'h50);
      wr(1, 7'h2a, 8'h1c);
      wr(1, 7'h2c, 8'h06);
      wr(1, 7'h26, 8'h7f);
      cyc(3);
      chk(dacLeftRoute === 1'b1 && hplGain === 4'hf && hplMute === 1'b1, "left");
      chk(hprGain === 4'ha && hprMute === 1'b0 && spkGain === 2'h3 && spkMute, "gain");
      chk(hpLineout === 1'b1 && spkVolMute === 1'b1, "lineout or mute");
      wr(1, 7'h2c, 8'h02);
      wr(1, 7'h26, 8'hff);
      cyc(3);
      chk(!hpLineout && spkVolRoute && !spkVolMute && spkVolNow === 7'h7f, "route");
      wr(0, 7'h3f, 8'h00);
      wr(1, 7'h26, 8'hfc);
      cyc(2);
      chk(spkVolNow === 7'h7f || spkVolNow === 7'h7e, "volume jumped");
      cyc(16);
      chk(spkVolNow === 7'h7c, "volume target");
      for (int c = 0; c < 4; c++) begin
         wr(1, 7'h1f, {3'h0, c[1:0], 3'h0});
         cyc(1);
         chk(hpCmLevel === c[1:0], "common mode");
      end
      $display("test fields done");
   endtask : t_fields
   task automatic t_power();
      wr(1, 7'h1f, 8'hc2);
      wr(1, 7'h20, 8'h80);
      cyc(1);
      chk(hplOn === 1'b0, "stage up without soft start");
      cyc(14);
      chk(hplOn && hprOn && spkOn && spkSwitchEn === 1'b1, "all stages up");
      overTempPin <= 1'b1;
      cyc(5);
      chk(spkSwitchEn === 1'b0 && spkOn === 1'b1, "hot");
      rd(0, 7'h03, 8'h02);
      overTempPin <= 1'b0;
      cyc(5);
      chk(spkSwitchEn === 1'b1, "cooled");
      $display("test power done");
   endtask : t_power
   task automatic t_short();
      hplShortPin <= 1'b1;
      cyc(6);
      chk(hplOn === 1'b0 && hprOn === 1'b1, "left shutdown");
      rd(1, 7'h1f, 8'h43);
      hplShortPin <= 1'b0;
      rd(1, 7'h1f, 8'h43);
      wr(1, 7'h1f, 8'hc2);
      rd(1, 7'h1f, 8'hc2);
      cyc(14);
      chk(hplOn === 1'b1, "left back up");
      spkOverPin <= 1'b1;
      cyc(6);
      rd(1, 7'h20, 8'h01);
      wr(1, 7'h20, 8'h80);
      rd(1, 7'h20, 8'h01);
      spkOverPin <= 1'b0;
      cyc(3);
      wr(1, 7'h20, 8'h80);
      rd(1, 7'h20, 8'h80);
      cyc(14);
      chk(spkOn === 1'b1, "speaker back up");
      wr(1, 7'h1f, 8'hc0);
      hprShortPin <= 1'b1;
      cyc(6);
      chk(hprLimit && hprOn && hplLimit === 1'b0, "current limit");
      rd(1, 7'h1f, 8'hc1);
      hprShortPin <= 1'b0;
      swReset <= 1'b1;
      cyc(1);
      swReset <= 1'b0;
      rd(1, 7'h1f, 8'h00);
      $display("test short done");
   endtask : t_short
   task automatic t_mix();
      logic [15:0] exp [4] = '{16'h0100, 16'h0300, 16'h0200, 16'h0000};
      leftSample <= 16'h0100;
      rightSample <= 16'h0300;
      for (int m = 0; m < 4; m++) begin
         spkMixSel <= m[1:0];
         cyc(3);
         chk(spkSample === exp[m], "speaker mix");
      end
      $display("test mix done");
   endtask : t_mix
   task automatic final_report();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // watchdog: a hang counts as a failure
   initial begin
      #200us;
      failures++;
      final_report();
   end
   initial begin
      {rst_n, swReset, regWrite, regRead, regPage, regAddr, regWdata} = '0;
      {hplShortPin, hprShortPin, spkOverPin, overTempPin, spkMixSel} = '0;
      {leftSample, rightSample} = '0;
      cyc(3);
      rst_n <= 1'b1;
      cyc(3);
      t_regs();
      t_fields();
      t_power();
      t_short();
      t_mix();
      final_report();
   end
endmodule : aod_output_ctrl_test
